// ---- src/vps_defs.svh ----
// register offsets, config fields, reset values and timing counts
`ifndef VPS_DEFS_SVH
`define VPS_DEFS_SVH

`define VPS_OFF_CFG     8'h00
`define VPS_OFF_DIV     8'h04
`define VPS_OFF_STAT    8'h08
`define VPS_RESP_OKAY   2'b00
`define VPS_RESP_SLVERR 2'b10

`define VPS_CFG_RST     32'h00800000
`define VPS_DIV_RST     32'h0004004e

`define VPS_CF_SLAVE    0
`define VPS_CF_FMT      2:1
`define VPS_CF_SLOT8    3
`define VPS_CF_L16      4
`define VPS_CF_COMP     5
`define VPS_CF_LE       6
`define VPS_CF_PAD      8:7
`define VPS_CF_ATT      11:9
`define VPS_CF_REL      13:12
`define VPS_CF_NLINK    15:14
`define VPS_CF_LSLOT0   16
`define VPS_CF_RATE     23:22
`define VPS_CF_SRC48    24
`define VPS_DV_HALF     15:0
`define VPS_DV_SLIM     23:16

`define VPS_AHZ         40000000
`define VPS_F128K       128000
`define VPS_F256K       256000
`define VPS_F512K       512000
`define VPS_FRAME_HZ    8000
`define VPS_HALF(f)     ((`VPS_AHZ) / (2 * (f)))
`define VPS_FLEN(f)     ((f) / `VPS_FRAME_HZ)
`define VPS_LONG_STROBE 8

`endif

// ---- src/voice_pcm_pkg.sv ----
// types shared by the voice serial port
`default_nettype none
package voice_pcm_pkg;
  typedef enum logic [1:0] {FMT_LONG = 2'd0, FMT_SHORT = 2'd1, FMT_ISDN = 2'd2} frame_fmt_e;
  typedef enum logic [1:0] {PAD_SIGN = 2'd0, PAD_ZERO = 2'd1, PAD_ATTEN = 2'd2} pad_e;
  typedef enum logic [1:0] {REL_NONE = 2'd0, REL_FALL = 2'd1, REL_RISE = 2'd2} rel_e;
  typedef enum logic [1:0] {ST_HUNT = 2'b01, ST_RUN = 2'b10} eng_st_e;
endpackage : voice_pcm_pkg
`default_nettype wire

// ---- src/pin_sync.sv ----
// two-flop synchroniser for pin inputs
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // pins in, synced out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;
endmodule : pin_sync
`default_nettype wire

// ---- src/voice_axil_slave.sv ----
// axi4-lite register file of the voice serial port
`include "vps_defs.svh"
`default_nettype none
module voice_axil_slave (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // read channels
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // register contents
  output logic      [31:0] cfg_word,
  output logic      [31:0] div_word,
  input  wire logic [31:0] stat_word
);
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, cfg_q, cfg_d, div_q, div_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
  endfunction : merge

  assign awready = !aw_q && !bv_q;
  assign wready  = !w_q && !bv_q;
  assign arready = !rv_q;

  always_comb
  begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    cfg_d = cfg_q; div_d = div_q;
    if (awvalid && awready)
    begin
      aw_d = 1'b1;
      awa_d = awaddr;
    end
    if (wvalid && wready)
    begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (aw_q && w_q)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = `VPS_RESP_OKAY;
      case ({awa_q[7:2], 2'b00})
        `VPS_OFF_CFG: cfg_d = merge(cfg_q, wd_q, ws_q);
        `VPS_OFF_DIV: div_d = merge(div_q, wd_q, ws_q);
        `VPS_OFF_STAT: br_d = `VPS_RESP_OKAY;
        default: br_d = `VPS_RESP_SLVERR;
      endcase
    end
    if (bv_q && bready)
      bv_d = 1'b0;
    if (arvalid && arready)
    begin
      rv_d = 1'b1;
      rr_d = `VPS_RESP_OKAY;
      case ({araddr[7:2], 2'b00})
        `VPS_OFF_CFG: rd_d = cfg_q;
        `VPS_OFF_DIV: rd_d = div_q;
        `VPS_OFF_STAT: rd_d = stat_word;
        default:
        begin
          rd_d = 32'h00000000;
          rr_d = `VPS_RESP_SLVERR;
        end
      endcase
    end
    else if (rv_q && rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0; awa_q <= 8'h00; w_q <= 1'b0; wd_q <= 32'h0; ws_q <= 4'h0;
      bv_q <= 1'b0; br_q <= 2'b00; rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'b00;
      cfg_q <= `VPS_CFG_RST;
      div_q <= `VPS_DIV_RST;
    end
    else
    begin
      aw_q <= aw_d; awa_q <= awa_d; w_q <= w_d; wd_q <= wd_d; ws_q <= ws_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
      cfg_q <= cfg_d;
      div_q <= div_d;
    end
  end

  assign bvalid   = bv_q;
  assign bresp    = br_q;
  assign rvalid   = rv_q;
  assign rdata    = rd_q;
  assign rresp    = rr_q;
  assign cfg_word = cfg_q;
  assign div_word = div_q;
endmodule : voice_axil_slave
`default_nettype wire

// ---- src/voice_pcm_serial_port.sv ----
// voice serial port: strobe/clock engine, slot mapping and sample framing
// Contract
// - master drives clock and strobe, slave accepts
// - long format: strobe rise starts word
// - master long strobe lasts eight clocks
// - capture on falling, launch on rising edge
// - output released after last bit, selectable edge
// - short format: strobe fall, one clock
// - three links on any of slots 0-3
// - isdn mode carries two bearer channels
// - isdn frame starts on strobe rise, 8kHz
// - slots 8 or 16 clocks, 8-bit only short
// - 13/16-bit linear, mu-law, A-law formats
// - one sample per active slot per frame
// - bit order selectable little or big
// - 16-clock slots padded sign, zero or attenuation
// - master clock from fixed rates or divider
// - samples move to links directly in hardware
// - all options from one configuration word; the divider half period and frame length sit in the DIV register
// - reset config: slot0, 13-bit, long, master 256k
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "vps_defs.svh"
`default_nettype none
module voice_pcm_serial_port (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [7:0]        awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic      [1:0]        bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [7:0]        araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  // serial pins
  input  wire logic              bclk_in,
  output logic                   bclk_out,
  output logic                   bclk_oe,
  input  wire logic              strb_in,
  output logic                   strb_out,
  output logic                   strb_oe,
  input  wire logic              sdin,
  output logic                   sdout,
  output logic                   sdout_oe,
  // voice links
  input  wire logic [2:0][15:0]  link_tx_data,
  output logic      [2:0]        link_tx_taken,
  output logic      [2:0][15:0]  link_rx_data,
  output logic      [2:0]        link_rx_valid
);
  logic [31:0] cfg, dvc;
  logic [2:0]  sy;
  logic        master_m, isdn_m, slot8, le, clk_l, sync_l, din_l, rise_ev, fall_ev, start_ev, launch;
  voice_pcm_pkg::frame_fmt_e fmt;
  voice_pcm_pkg::rel_e       rel;
  voice_pcm_pkg::eng_st_e    st_q, st_d;
  logic [15:0] half, gdiv_q, gdiv_d, frm_q, frm_d;
  logic [10:0] flen, gpos_q, gpos_d;
  logic        gclk_q, gclk_d, gsync_q, gsync_d, clk_p_q, sync_p_q, armed_q, armed_d;
  logic [6:0]  pos_q, pos_d, pi_l, pi_f;
  logic [2:0]  own_l, own_f, en_mask, tk_q, tk_d, rxv_q, rxv_d;
  logic        dout_q, dout_d, oe_q, oe_d;
  logic [15:0] acc_q, acc_d, wl;
  logic [2:0][15:0] hold_q, hold_d, rxd_q, rxd_d;
  logic [3:0]  hcnt_q;

  voice_axil_slave u_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .cfg_word(cfg), .div_word(dvc),
    .stat_word({frm_q, 8'h00, st_q == voice_pcm_pkg::ST_RUN, pos_q})
  );

  pin_sync #(.W(3)) u_sync (
    .aclk(aclk), .aresetn(aresetn),
    .pin({sdin, strb_in, bclk_in}), .synced(sy)
  );

  function automatic logic [15:0] rate_half(input logic [1:0] r);
    case (r)
      2'b10: rate_half = 16'(`VPS_HALF(`VPS_F256K));
      2'b11: rate_half = 16'(`VPS_HALF(`VPS_F512K));
      default: rate_half = 16'(`VPS_HALF(`VPS_F128K));
    endcase
  endfunction : rate_half

  function automatic logic [10:0] rate_flen(input logic [1:0] r);
    case (r)
      2'b10: rate_flen = 11'(`VPS_FLEN(`VPS_F256K));
      2'b11: rate_flen = 11'(`VPS_FLEN(`VPS_F512K));
      default: rate_flen = 11'(`VPS_FLEN(`VPS_F128K));
    endcase
  endfunction : rate_flen

  // position decode: {in range, slot, bit}
  function automatic logic [6:0] pinfo(input logic [6:0] p, input logic s8);
    if (s8)
      pinfo = {p[6:5] == 2'b00, p[4:3], 1'b0, p[2:0]};
    else
      pinfo = {!p[6], p[5:4], p[3:0]};
  endfunction : pinfo

  function automatic logic [2:0] links_on(input logic [31:0] c, input logic im);
    if (im)
      links_on = 3'b011;
    else
      case (c[`VPS_CF_NLINK])
        2'd0: links_on = 3'b001;
        2'd1: links_on = 3'b011;
        default: links_on = 3'b111;
      endcase
  endfunction : links_on

  // owner of a slot: {hit, link index}, lowest link wins
  function automatic logic [2:0] slot_owner(input logic [1:0] s, input logic [31:0] c, input logic im);
    logic [2:0] r;
    logic [2:0] en;
    logic [1:0] ls;
    r = 3'b000;
    en = links_on(c, im);
    for (int i = 2; i >= 0; i--)
    begin
      ls = im ? 2'(i) : c[`VPS_CF_LSLOT0 + 2*i +: 2];
      if (en[i] && ls == s)
        r = {1'b1, 2'(i)};
    end
    slot_owner = r;
  endfunction : slot_owner

  function automatic logic [15:0] build_word(input logic [15:0] s, input logic [31:0] c, input logic s8);
    voice_pcm_pkg::pad_e p;
    p = voice_pcm_pkg::pad_e'(c[`VPS_CF_PAD]);
    if (s8)
      build_word = {8'h00, s[7:0]};
    else if (c[`VPS_CF_COMP])
      case (p)
        voice_pcm_pkg::PAD_SIGN: build_word = {{8{s[7]}}, s[7:0]};
        voice_pcm_pkg::PAD_ZERO: build_word = {s[7:0], 8'h00};
        default: build_word = {s[7:0], 5'h00, c[`VPS_CF_ATT]};
      endcase
    else if (c[`VPS_CF_L16])
      build_word = s;
    else
      case (p)
        voice_pcm_pkg::PAD_SIGN: build_word = {{3{s[12]}}, s[12:0]};
        voice_pcm_pkg::PAD_ZERO: build_word = {s[12:0], 3'h0};
        default: build_word = {s[12:0], c[`VPS_CF_ATT]};
      endcase
  endfunction : build_word

  function automatic logic [15:0] split_word(input logic [15:0] w, input logic [31:0] c, input logic s8);
    logic sgn;
    sgn = c[`VPS_CF_PAD] == 2'd0;
    if (s8)
      split_word = {8'h00, w[7:0]};
    else if (c[`VPS_CF_COMP])
      split_word = sgn ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
    else if (c[`VPS_CF_L16])
      split_word = w;
    else
      split_word = sgn ? {{3{w[12]}}, w[12:0]} : {{3{w[15]}}, w[15:3]};
  endfunction : split_word

  // serial index of a bit within the slot word
  function automatic logic [3:0] bit_idx(input logic [3:0] b, input logic s8, input logic l);
    bit_idx = l ? b : ((s8 ? 4'd7 : 4'd15) - b);
  endfunction : bit_idx

  assign master_m = !cfg[`VPS_CF_SLAVE];
  assign fmt      = voice_pcm_pkg::frame_fmt_e'(cfg[`VPS_CF_FMT]);
  assign rel      = voice_pcm_pkg::rel_e'(cfg[`VPS_CF_REL]);
  assign isdn_m   = fmt == voice_pcm_pkg::FMT_ISDN;
  // eight-clock slots only for isdn or when chosen
  assign slot8    = cfg[`VPS_CF_SLOT8] | isdn_m;
  assign le       = cfg[`VPS_CF_LE];
  assign en_mask  = links_on(cfg, isdn_m);
  assign half     = cfg[`VPS_CF_SRC48] ? dvc[`VPS_DV_HALF] : rate_half(cfg[`VPS_CF_RATE]);
  assign flen     = cfg[`VPS_CF_SRC48] ? {dvc[`VPS_DV_SLIM], 3'b000} : rate_flen(cfg[`VPS_CF_RATE]);

  // master clock and strobe generator
  always_comb
  begin
    gdiv_d = gdiv_q + 16'h1;
    gclk_d = gclk_q;
    gsync_d = gsync_q;
    gpos_d = gpos_q;
    if (!master_m)
    begin
      gdiv_d = 16'h0;
      gclk_d = 1'b0;
      gsync_d = 1'b0;
      gpos_d = 11'h7ff;
    end
    else if (gdiv_q + 16'h1 >= half)
    begin
      gdiv_d = 16'h0;
      gclk_d = !gclk_q;
      if (!gclk_q)
      begin
        gpos_d = (gpos_q >= flen - 11'h1) ? 11'h0 : gpos_q + 11'h1;
        // short strobe one clock before word
        if (fmt == voice_pcm_pkg::FMT_SHORT)
          gsync_d = gpos_d == flen - 11'h1;
        else
          gsync_d = gpos_d < 11'(`VPS_LONG_STROBE);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gdiv_q <= 16'h0;
      gclk_q <= 1'b0;
      gsync_q <= 1'b0;
      gpos_q <= 11'h7ff;
    end
    else
    begin
      gdiv_q <= gdiv_d;
      gclk_q <= gclk_d;
      gsync_q <= gsync_d;
      gpos_q <= gpos_d;
    end
  end

  assign clk_l    = master_m ? gclk_q : sy[0];
  assign sync_l   = master_m ? gsync_q : sy[1];
  assign din_l    = sy[2];
  assign bclk_out = gclk_q;
  assign strb_out = gsync_q;
  assign bclk_oe  = master_m;
  assign strb_oe  = master_m;
  assign rise_ev  = clk_l && !clk_p_q;
  assign fall_ev  = !clk_l && clk_p_q;
  assign start_ev = (fmt == voice_pcm_pkg::FMT_SHORT) ? (!sync_l && sync_p_q) : (sync_l && !sync_p_q);

  // bit position engine
  always_comb
  begin
    st_d = st_q;
    pos_d = pos_q;
    frm_d = frm_q;
    armed_d = armed_q | fall_ev;
    launch = 1'b0;
    if (start_ev)
    begin
      st_d = voice_pcm_pkg::ST_RUN;
      pos_d = 7'h0;
      frm_d = frm_q + 16'h1;
      armed_d = 1'b0;
      launch = 1'b1;
    end
    else if (rise_ev && armed_q && st_q == voice_pcm_pkg::ST_RUN)
    begin
      pos_d = (&pos_q) ? pos_q : pos_q + 7'h1;
      armed_d = 1'b0;
      launch = 1'b1;
    end
  end

  // sample path between links and pins
  assign pi_l  = pinfo(pos_d, slot8);
  assign pi_f  = pinfo(pos_q, slot8);
  assign own_l = slot_owner(pi_l[5:4], cfg, isdn_m) & {3{pi_l[6]}};
  assign own_f = slot_owner(pi_f[5:4], cfg, isdn_m) & {3{pi_f[6]}};

  always_comb
  begin
    dout_d = dout_q;
    oe_d = oe_q;
    acc_d = acc_q;
    hold_d = hold_q;
    rxd_d = rxd_q;
    rxv_d = 3'b000;
    tk_d = 3'b000;
    wl = 16'h0;
    // one sample per link per frame
    if (start_ev)
    begin
      hold_d = link_tx_data;
      tk_d = en_mask;
    end
    if (launch)
    begin
      wl = build_word(hold_d[own_l[1:0]], cfg, slot8);
      if (own_l[2])
      begin
        dout_d = wl[bit_idx(pi_l[3:0], slot8, le)];
        oe_d = 1'b1;
      end
      else
        oe_d = rel == voice_pcm_pkg::REL_NONE;
    end
    if (fall_ev && st_q == voice_pcm_pkg::ST_RUN && own_f[2])
    begin
      acc_d[bit_idx(pi_f[3:0], slot8, le)] = din_l;
      if (pi_f[3:0] == (slot8 ? 4'd7 : 4'd15))
      begin
        rxd_d[own_f[1:0]] = split_word(acc_d, cfg, slot8);
        rxv_d[own_f[1:0]] = 1'b1;
        // release on falling edge of last bit
        if (rel == voice_pcm_pkg::REL_FALL)
          oe_d = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= voice_pcm_pkg::ST_HUNT;
      pos_q <= 7'h7f;
      frm_q <= 16'h0;
      armed_q <= 1'b0;
      clk_p_q <= 1'b0;
      sync_p_q <= 1'b0;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      acc_q <= 16'h0;
      hold_q <= '0;
      rxd_q <= '0;
      rxv_q <= 3'b000;
      tk_q <= 3'b000;
    end
    else
    begin
      st_q <= st_d;
      pos_q <= pos_d;
      frm_q <= frm_d;
      armed_q <= armed_d;
      clk_p_q <= clk_l;
      sync_p_q <= sync_l;
      dout_q <= dout_d;
      oe_q <= oe_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      rxd_q <= rxd_d;
      rxv_q <= rxv_d;
      tk_q <= tk_d;
    end
  end

  assign sdout         = dout_q;
  assign sdout_oe      = oe_q;
  assign link_rx_data  = rxd_q;
  assign link_rx_valid = rxv_q;
  assign link_tx_taken = tk_q;

  // strobe width helper
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hcnt_q <= 4'h0;
    else if (master_m && rise_ev && gsync_q)
      hcnt_q <= sync_p_q ? hcnt_q + 4'h1 : 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_strobe_fall;
    master_m && $fell(gsync_q) && $stable(cfg);
  endsequence

  AST_SLAVE_QUIET:
    assert property (!master_m |=> !gclk_q && !gsync_q) else $error("generator runs as slave");
  AST_LONG_STROBE_8:
    assert property (s_strobe_fall |-> fmt == voice_pcm_pkg::FMT_SHORT || hcnt_q == 4'd8)
      else $error("long strobe not eight clocks");
  AST_SHORT_STROBE_1:
    assert property (s_strobe_fall |-> fmt != voice_pcm_pkg::FMT_SHORT || hcnt_q == 4'd1)
      else $error("short strobe not one clock");
  AST_LONG_START:
    assert property (master_m && start_ev && fmt != voice_pcm_pkg::FMT_SHORT |-> gpos_q == 11'h0)
      else $error("long frame start off bit zero");
  AST_FRAME_RESTART:
    assert property (start_ev |=> pos_q == 7'h0 && st_q == voice_pcm_pkg::ST_RUN) else $error("no restart");
  AST_CAPTURE_FALL:
    assert property (!fall_ev |=> $stable(acc_q)) else $error("capture off falling edge");
  AST_LAUNCH_RISE:
    assert property (!launch |=> $stable(dout_q)) else $error("launch off rising edge");
  AST_RELEASE_FALL:
    assert property (rel == voice_pcm_pkg::REL_FALL && fall_ev && st_q == voice_pcm_pkg::ST_RUN && own_f[2]
      && pi_f[3:0] == (slot8 ? 4'd7 : 4'd15) |=> !sdout_oe) else $error("output not released");
  AST_NO_RELEASE:
    assert property (rel == voice_pcm_pkg::REL_NONE && launch |=> sdout_oe) else $error("output released");
  AST_RX_ON_FALL:
    assert property (|link_rx_valid |-> $past(fall_ev)) else $error("sample outside falling edge");
  AST_TX_TAKEN:
    assert property (start_ev && $stable(cfg) |=> link_tx_taken == $past(en_mask)) else $error("tx not taken");
  AST_ISDN_TWO:
    assert property (isdn_m && $stable(cfg) |=> !link_rx_valid[2] && !link_tx_taken[2])
      else $error("third link active in isdn mode");
endmodule : voice_pcm_serial_port
`default_nettype wire

// ---- bench/codec_model.sv ----
// behavioural codec at the far side of the serial port
`default_nettype none
module codec_model (
  // control
  input  wire logic        master_mode,
  input  wire logic [15:0] word,
  // serial pins
  input  wire logic        sdout,
  output logic             bclk,
  output logic             strb,
  output logic             sdin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        sd_q;
  logic [15:0] got;
  initial
  begin
    bclk = 1'b0;
    strb = 1'b0;
    sd_q = 1'b0;
    got  = 16'h0000;
  end
  // loop back while the port is master
  assign sdin = master_mode ? sdout : sd_q;
  // one short-strobe frame, clock still outside frames
  task automatic frame();
    strb <= 1'b1;
    for (int i = -1; i < 32; i++)
    begin
      bclk <= 1'b1;
      if (i == 0)
        strb <= 1'b0;
      // launch on rise, toggling once released
      sd_q <= (i >= 0 && i < 16) ? word[15 - i] : ~sd_q;
      #100;
      // port output taken at the falling edge
      if (i >= 0 && i < 16)
        got[15 - i] = sdout;
      bclk <= 1'b0;
      #100;
    end
  endtask : frame
endmodule : codec_model
`default_nettype wire

// ---- bench/voice_pcm_serial_port_tb.sv ----
// self-checking bench of the voice serial port
`include "vps_defs.svh"
`default_nettype none
module voice_pcm_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              aclk = 1'b0;
  logic              aresetn, awvalid, wvalid, bready, arvalid, rready, master_mode;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              bclk, strb, sdin, bclk_out, bclk_oe, strb_out, strb_oe, sdout, sdout_oe;
  logic [2:0][15:0]  tx, rx;
  logic [2:0]        taken, rx_valid;
  int                bad_count, n_tests, cyc;

  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc++;

  voice_pcm_serial_port dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .bclk_in(bclk),
    .bclk_out(bclk_out), .bclk_oe(bclk_oe), .strb_in(strb), .strb_out(strb_out), .strb_oe(strb_oe),
    .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe), .link_tx_data(tx), .link_tx_taken(taken),
    .link_rx_data(rx), .link_rx_valid(rx_valid));

  codec_model codec (.master_mode(master_mode), .word(16'h00a5), .sdout(sdout), .bclk(bclk),
    .strb(strb), .sdin(sdin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(`VPS_OFF_CFG, d, r);
    check(d, `VPS_CFG_RST);
    axi_read(`VPS_OFF_DIV, d, r);
    check(d, `VPS_DIV_RST);
    axi_read(8'h3c, d, r);
    check(32'(r), 32'(`VPS_RESP_SLVERR));
    axi_write(8'h3c, 32'h0000ffff, r);
    check(32'(r), 32'(`VPS_RESP_SLVERR));
    $display("test_regs finished");
  endtask : test_regs

  task automatic test_master();
    int          t0, falls;
    logic        pb;
    tx[0] <= 16'h1abc;
    while (strb_out !== 1'b0)
      @(negedge aclk);
    while (strb_out !== 1'b1)
      @(negedge aclk);
    t0 = cyc;
    falls = 0;
    pb = bclk_out;
    while (strb_out === 1'b1)
    begin
      @(negedge aclk);
      if (pb && !bclk_out)
        falls++;
      pb = bclk_out;
    end
    check(32'(falls), `VPS_LONG_STROBE);
    check(32'({bclk_oe, strb_oe}), 32'h00000003);
    while (strb_out !== 1'b1)
      @(negedge aclk);
    check(32'(cyc - t0), 2 * `VPS_HALF(`VPS_F256K) * `VPS_FLEN(`VPS_F256K));
    while (taken[0] !== 1'b1)
      @(negedge aclk);
    check(32'(taken), 32'h00000001);
    while (rx_valid[0] !== 1'b1)
      @(negedge aclk);
    check(32'(rx[0]), 32'h0000fabc);
    check(32'(sdout_oe), 32'h00000001);
    $display("test_master finished");
  endtask : test_master

  task automatic test_slave(input logic le);
    logic [1:0]  r;
    logic [15:0] w, wr, tr;
    w = 16'h00a5;
    wr = {<<{w}};
    tr = {<<{16'h1abc}};
    master_mode <= 1'b0;
    axi_write(`VPS_OFF_CFG, 32'h00800013 | {25'h0, le, 6'h0}, r);
    repeat (4) @(posedge aclk);
    check(32'({bclk_oe, strb_oe}), 32'h00000000);
    codec.frame();
    repeat (8) @(posedge aclk);
    check(32'(rx[0]), le ? 32'(wr) : 32'(w));
    check(32'(codec.got), le ? 32'(tr) : 32'h00001abc);
    $display("test_slave finished");
  endtask : test_slave

  task automatic test_isdn();
    logic [1:0] r;
    master_mode <= 1'b1;
    tx[1]       <= 16'h0033;
    axi_write(`VPS_OFF_CFG, 32'h00801004, r);
    while (taken[0] !== 1'b1)
      @(negedge aclk);
    check(32'(taken), 32'h00000003);
    while (rx_valid[0] !== 1'b1)
      @(negedge aclk);
    check(32'(rx[0]), 32'h000000bc);
    while (rx_valid[1] !== 1'b1)
      @(negedge aclk);
    check(32'(rx[1]), 32'h00000033);
    check(32'(sdout_oe), 32'h00000000);
    $display("test_isdn finished");
  endtask : test_isdn

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    tx = '0;
    master_mode = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_master();
    test_slave(1'b0);
    test_slave(1'b1);
    test_isdn();
    end_of_test();
  end

  initial
  begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule : voice_pcm_serial_port_tb
`default_nettype wire
